// *** common/exec_pkg.sv ***
// Shared constants and types of the instruction execution block
package exec_pkg;
   localparam int DATA_W = 8;
   localparam int DMEM_AW = 6;
   localparam int PROG_W = 16;
   localparam int PMEM_AW = 10;
   localparam int AXI_AW = 8;

   // Register byte addresses
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_WORK = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_TABLE_PTR = 8'h0c;
   localparam logic [7:0] ADDR_TABLE_HIGH = 8'h10;
   localparam logic [7:0] ADDR_DMEM_ADDR = 8'h14;
   localparam logic [7:0] ADDR_DMEM_DATA = 8'h18;
   localparam logic [7:0] ADDR_PMEM_ADDR = 8'h1c;
   localparam logic [7:0] ADDR_PMEM_DATA = 8'h20;

   // Operation codes in bits 4:0 of the instruction word
   localparam logic [4:0] OP_DECREMENT_SKIP_IF_NULL_MEM = 5'h00;
   localparam logic [4:0] OP_DECREMENT_SKIP_IF_NULL_WORK = 5'h01;
   localparam logic [4:0] OP_SET_BYTE = 5'h02;
   localparam logic [4:0] OP_SET_BIT = 5'h03;
   localparam logic [4:0] OP_INCREMENT_SKIP_IF_NULL_MEM = 5'h04;
   localparam logic [4:0] OP_INCREMENT_SKIP_IF_NULL_WORK = 5'h05;
   localparam logic [4:0] OP_SKIP_IF_BIT_ONE = 5'h06;
   localparam logic [4:0] OP_DIFFERENCE_TO_WORK = 5'h07;
   localparam logic [4:0] OP_DIFFERENCE_TO_MEMORY = 5'h08;
   localparam logic [4:0] OP_DIFFERENCE_IMMEDIATE = 5'h09;
   localparam logic [4:0] OP_NIBBLE_EXCHANGE_MEM = 5'h0a;
   localparam logic [4:0] OP_NIBBLE_EXCHANGE_WORK = 5'h0b;
   localparam logic [4:0] OP_SKIP_IF_NULL = 5'h0c;
   localparam logic [4:0] OP_COPY_SKIP_IF_NULL = 5'h0d;
   localparam logic [4:0] OP_SKIP_IF_BIT_ZERO = 5'h0e;
   localparam logic [4:0] OP_TABLE_READ_CURRENT_PAGE = 5'h0f;
   localparam logic [4:0] OP_TABLE_READ_FINAL_PAGE = 5'h10;
   localparam logic [4:0] OP_EXCLUSIVE_OR_TO_WORK = 5'h11;
   localparam logic [4:0] OP_EXCLUSIVE_OR_TO_MEMORY = 5'h12;
   localparam logic [4:0] OP_EXCLUSIVE_OR_IMMEDIATE = 5'h13;

   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [1:0] PAGE_LAST = 2'h3;
   localparam logic [1:0] CYCLES_PLAIN = 2'h1;
   localparam logic [1:0] CYCLES_SKIP = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;

   // Status word: flags 3:0, busy 4, skip 5, cycles 7:6
   typedef struct packed {
      logic arith_wrap_flag;
      logic zero;
      logic half_carry_flag;
      logic carry;
   } flags_t;

   typedef struct packed {
      logic [7:0] imm;
      logic [1:0] rsv;
      logic [5:0] addr;
      logic [2:0] bitsel;
      logic [4:0] op;
   } instr_t;

   typedef struct packed {
      logic [7:0] res;
      flags_t flags;
   } alu_t;

   typedef enum logic [1:0] {st_idle, st_fetch, st_exec, st_dummy} state_t;
endpackage : exec_pkg

// *** core/exec_core.sv ***
// Execution unit for skip, set, subtract, swap, table read and exclusive-or operations
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module exec_core
   import exec_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   state_t state_reg;
   instr_t instr_reg;
   flags_t flags_reg;
   logic [7:0] work_reg;
   logic [7:0] table_high_byte_reg;
   logic [7:0] table_pointer_reg;
   logic [1:0] table_page_reg;
   logic [DMEM_AW-1:0] dmem_addr_reg;
   logic [PMEM_AW-1:0] pmem_addr_reg;
   logic skip_reg;
   logic [1:0] cycles_reg;

   logic [7:0] dmem_rdata;
   logic [DMEM_AW-1:0] dmem_raddr;
   logic [DMEM_AW-1:0] dmem_waddr;
   logic [7:0] dmem_wdata;
   logic dmem_we;
   logic [PROG_W-1:0] pmem_rdata;
   logic [PMEM_AW-1:0] pmem_raddr;

   logic idle;
   logic in_exec;
   logic wr_go;
   logic wr_fire;
   logic wr_hit;
   logic rd_go;
   logic rd_fire;
   logic [31:0] wr_old;
   logic [31:0] wr_val;
   logic [7:0] aw_word;

   logic [7:0] alu_res;
   flags_t flags_next;
   logic put_mem;
   logic put_work;
   logic put_high;
   logic skip_c;
   alu_t sub_o;
   logic [7:0] xor_v;
   logic [7:0] mem_plus;
   logic [7:0] mem_minus;

   assign idle = (state_reg == st_idle);
   assign in_exec = (state_reg == st_exec);

   // Subtraction with inverted borrow as carry
   function automatic alu_t subtract(input logic [7:0] a, input logic [7:0] b,
                                     input flags_t f);
      logic [8:0] full;
      logic [4:0] low;
      alu_t o;
      full = {1'b0, a} + {1'b0, ~b} + 9'h001;
      low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      o.res = full[7:0];
      o.flags = f;
      o.flags.carry = full[8];
      o.flags.half_carry_flag = low[4];
      o.flags.arith_wrap_flag = (a[7] ^ b[7]) & (a[7] ^ full[7]);
      o.flags.zero = (full[7:0] == BYTE_ZERO);
      return o;
   endfunction : subtract

   // Byte lanes not strobed keep their present value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return m;
   endfunction : merge

   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case ({a[7:2], 2'b00})
         ADDR_INSTR: v = {8'h00, instr_reg};
         ADDR_WORK: v = {24'h00_0000, work_reg};
         ADDR_STATUS: v = {24'h00_0000, cycles_reg, skip_reg, ~idle, flags_reg};
         ADDR_TABLE_PTR: v = {22'h00_0000, table_page_reg, table_pointer_reg};
         ADDR_TABLE_HIGH: v = {24'h00_0000, table_high_byte_reg};
         ADDR_DMEM_ADDR: v = {26'h000_0000, dmem_addr_reg};
         ADDR_DMEM_DATA: v = {24'h00_0000, dmem_rdata};
         ADDR_PMEM_ADDR: v = {22'h00_0000, pmem_addr_reg};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction : read_word

   function automatic logic mapped(input logic [7:0] a);
      return ({a[7:2], 2'b00} <= ADDR_PMEM_DATA);
   endfunction : mapped

   // Write channel: address and data taken together, only while idle
   assign aw_word = {awaddr[7:2], 2'b00};
   assign wr_go = awvalid & wvalid & ~awready & ~bvalid & idle;
   assign wr_fire = awready & awvalid & wvalid;
   assign wr_hit = mapped(awaddr) & (aw_word != ADDR_TABLE_HIGH);
   // Process form so the old word follows every register that the lookup reads
   always_comb begin
      wr_old = read_word(awaddr);
   end
   assign wr_val = merge(wr_old, wdata, wstrb);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
      end else begin
         awready <= wr_go;
         wready <= wr_go;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read channel: held off while an instruction runs
   assign rd_go = arvalid & ~arready & ~rvalid & idle;
   assign rd_fire = arready & arvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
      end else begin
         arready <= rd_go;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid <= 1'b1;
         rdata <= read_word(araddr);
         rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Host-side pointers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         table_pointer_reg <= 8'h00;
         table_page_reg <= 2'h0;
         dmem_addr_reg <= '0;
         pmem_addr_reg <= '0;
      end else if (wr_fire) begin
         if (aw_word == ADDR_TABLE_PTR) begin
            table_pointer_reg <= wr_val[7:0];
            table_page_reg <= wr_val[9:8];
         end
         if (aw_word == ADDR_DMEM_ADDR) begin
            dmem_addr_reg <= wr_val[DMEM_AW-1:0];
         end
         if (aw_word == ADDR_PMEM_ADDR) begin
            pmem_addr_reg <= wr_val[PMEM_AW-1:0];
         end
      end
   end

   // Instruction sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= st_idle;
         instr_reg <= '0;
      end else begin
         unique case (state_reg)
            st_idle: begin
               if (wr_fire && aw_word == ADDR_INSTR) begin
                  instr_reg <= instr_t'(wr_val[23:0]);
                  state_reg <= st_fetch;
               end
            end
            st_fetch: state_reg <= st_exec;
            st_exec: state_reg <= skip_c ? st_dummy : st_idle;
            st_dummy: state_reg <= st_idle;
         endcase
      end
   end

   // Operand memories
   assign dmem_raddr = (state_reg == st_fetch) ? instr_reg.addr : dmem_addr_reg;
   assign dmem_we = (in_exec & put_mem) | (wr_fire & aw_word == ADDR_DMEM_DATA);
   assign dmem_waddr = in_exec ? instr_reg.addr : dmem_addr_reg;
   assign dmem_wdata = in_exec ? alu_res : wr_val[7:0];
   assign pmem_raddr = {(instr_reg.op == OP_TABLE_READ_FINAL_PAGE) ? PAGE_LAST
                        : table_page_reg, table_pointer_reg};

   mem_store #(.WIDTH(DATA_W), .AW(DMEM_AW)) data_mem (
      .aclk(aclk),
      .we(dmem_we),
      .waddr(dmem_waddr),
      .wdata(dmem_wdata),
      .raddr(dmem_raddr),
      .rdata(dmem_rdata)
   );

   mem_store #(.WIDTH(PROG_W), .AW(PMEM_AW)) prog_mem (
      .aclk(aclk),
      .we(wr_fire & aw_word == ADDR_PMEM_DATA),
      .waddr(pmem_addr_reg),
      .wdata(wr_val[PROG_W-1:0]),
      .raddr(pmem_raddr),
      .rdata(pmem_rdata)
   );

   // Operation decode and datapath
   assign mem_plus = dmem_rdata + BYTE_ONE;
   assign mem_minus = dmem_rdata - BYTE_ONE;

   always_comb begin
      sub_o = subtract(work_reg, (instr_reg.op == OP_DIFFERENCE_IMMEDIATE) ?
                       instr_reg.imm : dmem_rdata, flags_reg);
      xor_v = work_reg ^ ((instr_reg.op == OP_EXCLUSIVE_OR_IMMEDIATE) ?
                          instr_reg.imm : dmem_rdata);
      alu_res = dmem_rdata;
      flags_next = flags_reg;
      put_mem = 1'b0;
      put_work = 1'b0;
      put_high = 1'b0;
      skip_c = 1'b0;
      case (instr_reg.op)
         OP_DECREMENT_SKIP_IF_NULL_MEM: begin
            alu_res = mem_minus;
            put_mem = 1'b1;
            skip_c = (mem_minus == BYTE_ZERO);
         end
         OP_DECREMENT_SKIP_IF_NULL_WORK: begin
            alu_res = mem_minus;
            put_work = 1'b1;
            skip_c = (mem_minus == BYTE_ZERO);
         end
         OP_SET_BYTE: begin
            alu_res = BYTE_ONES;
            put_mem = 1'b1;
         end
         OP_SET_BIT: begin
            alu_res = dmem_rdata | (BYTE_ONE << instr_reg.bitsel);
            put_mem = 1'b1;
         end
         OP_INCREMENT_SKIP_IF_NULL_MEM: begin
            alu_res = mem_plus;
            put_mem = 1'b1;
            skip_c = (mem_plus == BYTE_ZERO);
         end
         OP_INCREMENT_SKIP_IF_NULL_WORK: begin
            alu_res = mem_plus;
            put_work = 1'b1;
            skip_c = (mem_plus == BYTE_ZERO);
         end
         OP_SKIP_IF_BIT_ONE: skip_c = dmem_rdata[instr_reg.bitsel];
         OP_SKIP_IF_BIT_ZERO: skip_c = ~dmem_rdata[instr_reg.bitsel];
         OP_DIFFERENCE_TO_WORK, OP_DIFFERENCE_IMMEDIATE: begin
            alu_res = sub_o.res;
            flags_next = sub_o.flags;
            put_work = 1'b1;
         end
         OP_DIFFERENCE_TO_MEMORY: begin
            alu_res = sub_o.res;
            flags_next = sub_o.flags;
            put_mem = 1'b1;
         end
         OP_NIBBLE_EXCHANGE_MEM: begin
            alu_res = {dmem_rdata[3:0], dmem_rdata[7:4]};
            put_mem = 1'b1;
         end
         OP_NIBBLE_EXCHANGE_WORK: begin
            alu_res = {dmem_rdata[3:0], dmem_rdata[7:4]};
            put_work = 1'b1;
         end
         OP_SKIP_IF_NULL: skip_c = (dmem_rdata == BYTE_ZERO);
         OP_COPY_SKIP_IF_NULL: begin
            put_work = 1'b1;
            skip_c = (dmem_rdata == BYTE_ZERO);
         end
         OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_FINAL_PAGE: begin
            alu_res = pmem_rdata[7:0];
            put_mem = 1'b1;
            put_high = 1'b1;
         end
         OP_EXCLUSIVE_OR_TO_WORK, OP_EXCLUSIVE_OR_IMMEDIATE: begin
            alu_res = xor_v;
            put_work = 1'b1;
            flags_next.zero = (xor_v == BYTE_ZERO);
         end
         OP_EXCLUSIVE_OR_TO_MEMORY: begin
            alu_res = xor_v;
            put_mem = 1'b1;
            flags_next.zero = (xor_v == BYTE_ZERO);
         end
         default: ;
      endcase
   end

   // Working register: executed result first, else host write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         work_reg <= WORK_RST;
      end else if (in_exec && put_work) begin
         work_reg <= alu_res;
      end else if (wr_fire && aw_word == ADDR_WORK) begin
         work_reg <= wr_val[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_reg <= flags_t'(FLAGS_RST);
      end else if (in_exec) begin
         flags_reg <= flags_next;
      end else if (wr_fire && aw_word == ADDR_STATUS) begin
         flags_reg <= flags_t'(wr_val[3:0]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         table_high_byte_reg <= 8'h00;
      end else if (in_exec && put_high) begin
         table_high_byte_reg <= pmem_rdata[PROG_W-1:8];
      end
   end

   // Last instruction outcome for software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         skip_reg <= 1'b0;
         cycles_reg <= 2'h0;
      end else if (in_exec) begin
         skip_reg <= skip_c;
         cycles_reg <= skip_c ? CYCLES_SKIP : CYCLES_PLAIN;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_dummy_tail;
      (state_reg == st_dummy) ##1 (state_reg == st_idle);
   endsequence

   a_skip_dummy_cycle: assert property (in_exec && skip_c |=> seq_dummy_tail)
      else $error("taken skip did not insert one dummy cycle");
   a_plain_no_dummy: assert property (in_exec && !skip_c |=> idle)
      else $error("untaken skip held an extra cycle");
   a_dec_mem_write: assert property (in_exec && instr_reg.op == OP_DECREMENT_SKIP_IF_NULL_MEM
      |-> dmem_we && dmem_wdata == 8'(dmem_rdata - 8'h01) && skip_c == (dmem_rdata == 8'h01))
      else $error("decrement to memory wrong");
   a_dec_work_kept: assert property (in_exec && instr_reg.op == OP_DECREMENT_SKIP_IF_NULL_WORK
      |=> work_reg == 8'($past(dmem_rdata) - 8'h01) && flags_reg == $past(flags_reg))
      else $error("decrement to working wrong");
   a_set_byte_ones: assert property (in_exec && instr_reg.op == OP_SET_BYTE
      |-> dmem_we && dmem_wdata == 8'hff)
      else $error("set byte did not write all ones");
   a_inc_work_skip: assert property (in_exec && instr_reg.op == OP_INCREMENT_SKIP_IF_NULL_WORK
      && dmem_rdata == 8'hff |=> work_reg == 8'h00 ##0 state_reg == st_dummy)
      else $error("increment wrap did not skip");
   a_bit_one_skip: assert property (in_exec && instr_reg.op == OP_SKIP_IF_BIT_ONE
      |-> !dmem_we ##1 (state_reg == st_dummy) == $past(dmem_rdata[instr_reg.bitsel]))
      else $error("bit test skip wrong");
   a_carry_borrow: assert property (in_exec && instr_reg.op == OP_DIFFERENCE_TO_WORK
      |=> flags_reg.carry == ($past(work_reg) >= $past(dmem_rdata)))
      else $error("carry is not the inverted borrow");
   a_swap_work_val: assert property (in_exec && instr_reg.op == OP_NIBBLE_EXCHANGE_WORK
      |=> work_reg == {$past(dmem_rdata[3:0]), $past(dmem_rdata[7:4])})
      else $error("nibble exchange to working wrong");
   a_xor_zero_flag: assert property (in_exec && instr_reg.op == OP_EXCLUSIVE_OR_TO_WORK
      |=> flags_reg.zero == (work_reg == 8'h00) && flags_reg.carry == $past(flags_reg.carry))
      else $error("exclusive-or flag update wrong");
   a_final_page_read: assert property (state_reg == st_fetch
      && instr_reg.op == OP_TABLE_READ_FINAL_PAGE |-> pmem_raddr[9:8] == 2'h3)
      else $error("final page table read used wrong page");
endmodule : exec_core

// *** core/mem_store.sv ***
// Single-port-write memory with registered read data
`timescale 1ns/1ps
module mem_store #(
   parameter int WIDTH = 8,
   parameter int AW = 6
) (
   input wire logic aclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] cells [0:(1<<AW)-1];

   always_ff @(posedge aclk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
   end

   always_ff @(posedge aclk) begin
      rdata <= cells[raddr];
   end
endmodule : mem_store

// *** tb/bus_master_model.sv ***
// Register bus master driving the execution block
`timescale 1ns/1ps
module bus_master_model
   import exec_pkg::*;
(
   input wire logic aclk,
   output logic [AXI_AW-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [AXI_AW-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : bus_master_model

// *** tb/test_mcu_instruction_exec_subset.sv ***
// Self-checking bench for the instruction execution block
`timescale 1ns/1ps
module test_mcu_instruction_exec_subset
   import exec_pkg::*;
();
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [AXI_AW-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   int num_errors, check_count, seed, m, w, fl, em, ew, efl, skp, pg, ptr, w1, w2, tw;
   int pick[4] = '{0, 1, 255, 128};
   instr_t ins;

   always #2.5 aclk = ~aclk;

   exec_core u_exec_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   bus_master_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));

   task check(input string n, input logic [7:0] s, input int e);
      check_count++;
      if (s !== e[7:0]) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e[7:0], s);
      end
   endtask : check

   task stop_test;
      if (num_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test

   task put(input logic [7:0] a, input int v);
      host.wr(a, 32'(v), r);
   endtask : put

   task get(input logic [7:0] a);
      host.rd(a, d, r);
   endtask : get

   // Subtract with all four flags, carry as inverted borrow
   function automatic int sub(int a, int b);
      int res;
      res = (a - b) & 255;
      efl = {28'h0, ((a ^ b) & (a ^ res) & 128) != 0, res == 0, (a & 15) >= (b & 15), a >= b};
      return res;
   endfunction : sub

   function automatic int zf(int res);
      efl[2] = res == 0;
      return res;
   endfunction : zf

   initial begin
      #200000;
      num_errors++;
      stop_test();
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      num_errors = 0;
      check_count = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      seed = $urandom(4);
      get(ADDR_WORK);
      check("work reset", d[7:0], WORK_RST);
      get(ADDR_STATUS);
      check("flags reset", {4'h0, d[3:0]}, FLAGS_RST);
      get(8'h24);
      check("unmapped read", 8'(r), RESP_SLVERR);
      put(8'h24, 1);
      check("unmapped write", 8'(r), RESP_SLVERR);
      put(ADDR_TABLE_HIGH, 1);
      check("table high write", 8'(r), RESP_SLVERR);
      // Every code with each corner byte, then random and undefined codes
      for (int i = 0; i < 120; i++) begin
         ins = '0;
         ins.op = 5'(i < 80 ? i % 20 : i < 110 ? $urandom_range(0, 19) : $urandom_range(20, 31));
         ins.bitsel = 3'($urandom);
         ins.addr = 6'($urandom);
         ins.imm = 8'($urandom);
         m = i < 80 ? pick[i / 20] : $urandom_range(0, 255);
         w = $urandom_range(0, 3) == 0 ? m : $urandom_range(0, 255);
         fl = $urandom_range(0, 15);
         pg = $urandom_range(0, 3);
         ptr = $urandom_range(0, 255);
         w1 = $urandom_range(0, 65535);
         w2 = $urandom_range(0, 65535);
         em = m;
         ew = w;
         efl = fl;
         tw = -1;
         put(ADDR_DMEM_ADDR, ins.addr);
         put(ADDR_DMEM_DATA, m);
         put(ADDR_WORK, w);
         put(ADDR_STATUS, fl);
         put(ADDR_TABLE_PTR, pg * 256 + ptr);
         put(ADDR_PMEM_ADDR, pg * 256 + ptr);
         put(ADDR_PMEM_DATA, w1);
         put(ADDR_PMEM_ADDR, 768 + ptr);
         put(ADDR_PMEM_DATA, w2);
         put(ADDR_INSTR, ins);
         case (ins.op)
            OP_DECREMENT_SKIP_IF_NULL_MEM: em = (m + 255) & 255;
            OP_DECREMENT_SKIP_IF_NULL_WORK: ew = (m + 255) & 255;
            OP_SET_BYTE: em = 255;
            OP_SET_BIT: em = m | (1 << ins.bitsel);
            OP_INCREMENT_SKIP_IF_NULL_MEM: em = (m + 1) & 255;
            OP_INCREMENT_SKIP_IF_NULL_WORK: ew = (m + 1) & 255;
            OP_DIFFERENCE_TO_WORK: ew = sub(w, m);
            OP_DIFFERENCE_TO_MEMORY: em = sub(w, m);
            OP_DIFFERENCE_IMMEDIATE: ew = sub(w, ins.imm);
            OP_NIBBLE_EXCHANGE_MEM: em = ((m << 4) | (m >> 4)) & 255;
            OP_NIBBLE_EXCHANGE_WORK: ew = ((m << 4) | (m >> 4)) & 255;
            OP_COPY_SKIP_IF_NULL: ew = m;
            OP_TABLE_READ_CURRENT_PAGE: tw = pg == 3 ? w2 : w1;
            OP_TABLE_READ_FINAL_PAGE: tw = w2;
            OP_EXCLUSIVE_OR_TO_WORK: ew = zf(w ^ m);
            OP_EXCLUSIVE_OR_TO_MEMORY: em = zf(w ^ m);
            OP_EXCLUSIVE_OR_IMMEDIATE: ew = zf(w ^ ins.imm);
            default: ;
         endcase
         case (ins.op)
            OP_DECREMENT_SKIP_IF_NULL_MEM, OP_INCREMENT_SKIP_IF_NULL_MEM: skp = em == 0;
            OP_DECREMENT_SKIP_IF_NULL_WORK, OP_INCREMENT_SKIP_IF_NULL_WORK: skp = ew == 0;
            OP_SKIP_IF_BIT_ONE: skp = (m >> ins.bitsel) & 1;
            OP_SKIP_IF_NULL, OP_COPY_SKIP_IF_NULL: skp = m == 0;
            OP_SKIP_IF_BIT_ZERO: skp = ~(m >> ins.bitsel) & 1;
            default: skp = 0;
         endcase
         if (tw >= 0) em = tw & 255;
         get(ADDR_WORK);
         check("work", d[7:0], ew);
         get(ADDR_STATUS);
         check("status", d[7:0], (skp ? 128 : 64) | skp << 5 | efl);
         put(ADDR_DMEM_ADDR, ins.addr);
         get(ADDR_DMEM_DATA);
         check("data byte", d[7:0], em);
         if (tw >= 0) begin
            get(ADDR_TABLE_HIGH);
            check("table high", d[7:0], tw >> 8);
         end
      end
      // Reset in mid-run clears working register and status
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      get(ADDR_WORK);
      check("work after reset", d[7:0], WORK_RST);
      get(ADDR_STATUS);
      check("status after reset", d[7:0], 8'h00);
      stop_test();
   end
endmodule : test_mcu_instruction_exec_subset
